//--- rtl/hrl_pkg.sv
// Purpose: shared constants and types of the hopping radio link control
// Assumes: 10 MHz system clock
// Notes: byte streams travel as hrl_byte_t
package hrl_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int DWELL_NS = 2000;
  localparam int DWELL_CYC = (DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRE_UNIT_NS = 100000;
  localparam int PRE_UNIT_CYC = (PRE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_NS = 200000;
  localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // channel plan
  // ****************************************
  localparam logic [7:0] CH_BAND_LOW = 8'hc8;
  localparam logic [7:0] CH_FIRST_OK = 8'hc9;
  localparam logic [5:0] CH_COUNT = 6'h33;
  localparam logic [5:0] HOP_STRIDE = 6'h13;
  localparam logic [19:0] BASE_KHZ = 20'hdc370;
  localparam logic [9:0] STEP_KHZ = 10'h1f4;
  localparam int PRE_MIN_CYC = (51 + 1) * DWELL_CYC;
  localparam int RX_WAIT_CYC = 2 * PRE_MIN_CYC;

  // ****************************************
  // payload buffer
  // ****************************************
  localparam int BUF_AW = 6;
  localparam logic [6:0] BUF_DEPTH = 7'h40;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PRE = 8'h04;
  localparam logic [7:0] REG_CFG = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam int CTRL_THR_LSB = 0;
  localparam int CTRL_LEN_LSB = 8;
  localparam int STAT_ST_LSB = 0;
  localparam int STAT_CH_LSB = 8;
  localparam int STAT_CNT_LSB = 16;
  localparam int STAT_DIS_BIT = 24;
  localparam int CFG_STANDBY_AWAKE_BIT = 4;
  localparam logic [7:0] THR_RST = 8'h0a;
  localparam logic [6:0] LEN_RST = 7'h40;
  localparam logic [15:0] PRE_RST = 16'h0014;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] NOISE_RST = 8'hff;

  typedef enum logic [3:0] {
    ST_IDLE, ST_FILL, ST_LOAD, ST_PREAMBLE, ST_STREAM, ST_TXWAIT, ST_SCAN, ST_RECV, ST_ACK
  } hrl_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } hrl_byte_t;

endpackage

//--- rtl/hrl_mem.sv
// Purpose: small word memory with registered read data
// Assumes: one write and one read port on the system clock
// Notes: read data appear the cycle after the address
`timescale 1ns/10ps
module hrl_mem #(
  parameter int W = 8,
  parameter int AW = 6,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata
);

  typedef struct packed {
    logic [(1<<AW)-1:0][W-1:0] arr;
    logic [W-1:0] rdata;
  } hrl_mem_state_t;

  hrl_mem_state_t r;
  hrl_mem_state_t next_r;

  always_comb begin
    next_r = r;
    if (i_we) begin
      next_r.arr[i_waddr] = i_wdata;
    end
    next_r.rdata = r.arr[i_raddr];
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r <= '{arr: {(1<<AW){INIT}}, rdata: '0};
    end else begin
      r <= next_r;
    end
  end

  assign o_rdata = r.rdata;

endmodule // hrl_mem

//--- rtl/hrl_link.sv
// Purpose: control of a hopping packet radio: host buffering, hop tx, scan rx
// Assumes: host uart decoder and transceiver are logic on the same clock
// Notes: mode pin is asynchronous and is synchronised
`timescale 1ns/10ps
module hrl_link (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire hrl_pkg::hrl_byte_t i_host_rx,
  output logic o_rts,
  output hrl_pkg::hrl_byte_t o_host_tx,
  input wire logic i_host_tx_ready,
  output hrl_pkg::hrl_byte_t o_trx_tx,
  input wire logic i_trx_tx_ready,
  output logic o_trx_tx_on,
  output logic o_trx_preamble,
  input wire logic i_trx_tx_done,
  output logic o_trx_rx_on,
  output logic [7:0] o_trx_channel,
  output logic [19:0] o_trx_freq_khz,
  input wire logic [7:0] i_trx_rssi,
  input wire hrl_pkg::hrl_byte_t i_trx_rx,
  output logic o_trx_rx_ready,
  input wire logic i_trx_pkt_detect,
  input wire logic i_trx_pkt_end,
  input wire logic i_trx_ack_req,
  output logic o_trx_ack_send,
  input wire logic i_radio_receive_disable,
  output logic o_low_power_state
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [5:0] ch_add(input logic [5:0] a, input logic [5:0] b);
    logic [6:0] s;
    s = {1'b0, a} + {1'b0, b};
    return (s >= {1'b0, hrl_pkg::CH_COUNT}) ? 6'(s - {1'b0, hrl_pkg::CH_COUNT}) : s[5:0];
  endfunction
  // index 0..50 stands for channels 201..251, so the band edges never appear
  function automatic logic [7:0] ch_num(input logic [5:0] idx);
    return hrl_pkg::CH_FIRST_OK + {2'h0, idx};
  endfunction
  function automatic logic [19:0] ch_khz(input logic [7:0] ch);
    logic [7:0] off;
    off = ch - hrl_pkg::CH_BAND_LOW;
    return hrl_pkg::BASE_KHZ + 20'(off) * 20'(hrl_pkg::STEP_KHZ);
  endfunction
  localparam logic [27:0] DWELL_END = 28'(hrl_pkg::DWELL_CYC - 1);
  localparam logic [27:0] GAP_END = 28'(hrl_pkg::GAP_CYC - 1);
  localparam logic [27:0] PRE_MIN = 28'(hrl_pkg::PRE_MIN_CYC);
  localparam logic [27:0] PRE_UNIT = 28'(hrl_pkg::PRE_UNIT_CYC);
  localparam logic [27:0] RX_WAIT = 28'(hrl_pkg::RX_WAIT_CYC);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    hrl_pkg::hrl_state_t st;
    logic [7:0] thr;
    logic [6:0] len;
    logic [15:0] pre;
    logic [7:0] cfg;
    logic [31:0] rdata;
    logic dis_s1;
    logic dis_s2;
    logic [6:0] wr_ptr;
    logic [6:0] rd_ptr;
    logic [27:0] timer;
    logic [5:0] hop_idx;
    logic [5:0] scan_idx;
    logic stage_ok;
    logic stage_wait;
    logic tx_on;
    logic preamble;
    logic detected;
    logic ack;
    hrl_pkg::hrl_byte_t ob0;
    hrl_pkg::hrl_byte_t ob1;
  } hrl_link_state_t;
  hrl_link_state_t r;
  hrl_link_state_t next_r;
  logic [7:0] buf_rdata;
  logic [7:0] noise_rdata;
  logic buf_we;
  logic noise_we;
  logic [7:0] noise_new;
  logic host_take;
  logic rx_take;
  logic tx_take;
  logic is_active;
  logic [27:0] pre_len;
  logic [8:0] noise_sum;
  // ****************************************
  // memories
  // ****************************************
  hrl_mem #(.W(8), .AW(hrl_pkg::BUF_AW), .INIT(8'h00)) u_payload (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_we(buf_we),
    .i_waddr(r.wr_ptr[5:0]),
    .i_wdata(i_host_rx.data),
    .i_raddr(r.rd_ptr[5:0]),
    .o_rdata(buf_rdata)
  );
  hrl_mem #(.W(8), .AW(6), .INIT(hrl_pkg::NOISE_RST)) u_noise (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_we(noise_we),
    .i_waddr(r.scan_idx),
    .i_wdata(noise_new),
    .i_raddr(r.scan_idx),
    .o_rdata(noise_rdata)
  );
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.dis_s1 = i_radio_receive_disable;
    next_r.dis_s2 = r.dis_s1;
    // host may send only while rts is low
    host_take = i_host_rx.valid && !o_rts && (r.wr_ptr < hrl_pkg::BUF_DEPTH);
    buf_we = host_take;
    rx_take = i_trx_rx.valid && o_trx_rx_ready;
    tx_take = o_trx_tx.valid && i_trx_tx_ready;
    noise_sum = {1'b0, noise_rdata} + {1'b0, r.thr};
    is_active = ({1'b0, i_trx_rssi} >= noise_sum);
    noise_new = noise_rdata - {2'h0, noise_rdata[7:2]} + {2'h0, i_trx_rssi[7:2]};
    noise_we = 1'b0;
    pre_len = (28'(r.pre) * PRE_UNIT < PRE_MIN) ? PRE_MIN : 28'(r.pre) * PRE_UNIT;
    // register bus
    next_r.rdata = 32'h0000_0000;
    if (i_wr) begin
      case (i_addr)
        hrl_pkg::REG_CTRL: begin
          next_r.thr = i_wdata[hrl_pkg::CTRL_THR_LSB +: 8];
          next_r.len = i_wdata[hrl_pkg::CTRL_LEN_LSB +: 7];
        end
        hrl_pkg::REG_PRE: next_r.pre = i_wdata[15:0];
        hrl_pkg::REG_CFG: next_r.cfg = i_wdata[7:0];
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        hrl_pkg::REG_CTRL: begin
          next_r.rdata[hrl_pkg::CTRL_THR_LSB +: 8] = r.thr;
          next_r.rdata[hrl_pkg::CTRL_LEN_LSB +: 7] = r.len;
        end
        hrl_pkg::REG_PRE: next_r.rdata[15:0] = r.pre;
        hrl_pkg::REG_CFG: next_r.rdata[7:0] = r.cfg;
        hrl_pkg::REG_STAT: begin
          next_r.rdata[hrl_pkg::STAT_ST_LSB +: 4] = r.st;
          next_r.rdata[hrl_pkg::STAT_CH_LSB +: 8] = o_trx_channel;
          next_r.rdata[hrl_pkg::STAT_CNT_LSB +: 7] = r.wr_ptr;
          next_r.rdata[hrl_pkg::STAT_DIS_BIT] = r.dis_s2;
        end
        default: ;
      endcase
    end
    // two-entry buffer toward the host
    if (o_host_tx.valid && i_host_tx_ready) begin
      next_r.ob0 = r.ob1;
      next_r.ob1 = '0;
    end
    if (rx_take) begin
      if (!next_r.ob0.valid) begin
        next_r.ob0 = '{valid: 1'b1, data: i_trx_rx.data};
      end else begin
        next_r.ob1 = '{valid: 1'b1, data: i_trx_rx.data};
      end
    end
    // payload staging: read data are valid one cycle after the pointer moves
    if (r.stage_wait) begin
      next_r.stage_wait = 1'b0;
      next_r.stage_ok = 1'b1;
    end
    if (tx_take) begin
      next_r.rd_ptr = r.rd_ptr + 7'h01;
      next_r.stage_ok = 1'b0;
      next_r.stage_wait = (r.rd_ptr + 7'h01) < r.wr_ptr;
    end
    if (host_take) begin
      next_r.wr_ptr = r.wr_ptr + 7'h01;
    end
    next_r.timer = r.timer + 28'h1;
    case (r.st)
      hrl_pkg::ST_IDLE: begin
        next_r.timer = '0;
        if (host_take) begin
          next_r.st = hrl_pkg::ST_FILL;
        end else if (!r.dis_s2) begin
          next_r.st = hrl_pkg::ST_SCAN;
        end
      end
      hrl_pkg::ST_FILL: begin
        if (host_take) begin
          next_r.timer = '0;
        end
        if ((next_r.wr_ptr >= r.len) || (next_r.wr_ptr == hrl_pkg::BUF_DEPTH) ||
            (r.timer >= GAP_END)) begin
          next_r.st = hrl_pkg::ST_LOAD;
          next_r.hop_idx = ch_add(r.hop_idx, hrl_pkg::HOP_STRIDE);
          next_r.rd_ptr = '0;
          next_r.stage_ok = 1'b0;
          next_r.stage_wait = 1'b1;
        end
      end
      hrl_pkg::ST_LOAD: begin
        if (tx_take) begin
          next_r.st = hrl_pkg::ST_PREAMBLE;
          next_r.tx_on = 1'b1;
          next_r.preamble = 1'b1;
          next_r.timer = '0;
        end
      end
      hrl_pkg::ST_PREAMBLE: begin
        if (r.timer >= pre_len - 28'h1) begin
          next_r.preamble = 1'b0;
          next_r.st = hrl_pkg::ST_STREAM;
        end
      end
      hrl_pkg::ST_STREAM: begin
        if (next_r.rd_ptr >= r.wr_ptr) begin
          next_r.st = hrl_pkg::ST_TXWAIT;
        end
      end
      hrl_pkg::ST_TXWAIT: begin
        if (i_trx_tx_done) begin
          next_r.tx_on = 1'b0;
          next_r.wr_ptr = '0;
          next_r.rd_ptr = '0;
          next_r.st = hrl_pkg::ST_IDLE;
        end
      end
      hrl_pkg::ST_SCAN: begin
        if (r.dis_s2) begin
          next_r.st = hrl_pkg::ST_IDLE;
        end else if (host_take) begin
          next_r.st = hrl_pkg::ST_FILL;
          next_r.timer = '0;
        end else if (r.timer >= DWELL_END) begin
          next_r.timer = '0;
          if (is_active) begin
            next_r.st = hrl_pkg::ST_RECV;
            next_r.detected = 1'b0;
          end else begin
            noise_we = 1'b1;
            next_r.scan_idx = ch_add(r.scan_idx, 6'h01);
          end
        end
      end
      hrl_pkg::ST_RECV: begin
        if (i_trx_pkt_detect) begin
          next_r.detected = 1'b1;
        end
        if (r.detected && i_trx_pkt_end) begin
          next_r.detected = 1'b0;
          next_r.timer = '0;
          if (i_trx_ack_req) begin
            next_r.st = hrl_pkg::ST_ACK;
            next_r.ack = 1'b1;
          end else begin
            next_r.st = hrl_pkg::ST_SCAN;
          end
        end else if (r.dis_s2 || (!r.detected && (r.timer >= RX_WAIT))) begin
          next_r.timer = '0;
          next_r.st = hrl_pkg::ST_SCAN;
        end
      end
      hrl_pkg::ST_ACK: begin
        if (i_trx_tx_done) begin
          next_r.ack = 1'b0;
          next_r.timer = '0;
          next_r.st = hrl_pkg::ST_SCAN;
        end
      end
      default: next_r.st = hrl_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r <= '{st: hrl_pkg::ST_IDLE, thr: hrl_pkg::THR_RST, len: hrl_pkg::LEN_RST,
             pre: hrl_pkg::PRE_RST, cfg: hrl_pkg::CFG_RST, default: '0};
    end else begin
      r <= next_r;
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  assign o_rdata = r.rdata;
  assign o_rts = !((r.st == hrl_pkg::ST_IDLE) || (r.st == hrl_pkg::ST_FILL) ||
                   (r.st == hrl_pkg::ST_SCAN)) || (r.wr_ptr == hrl_pkg::BUF_DEPTH);
  assign o_host_tx = r.ob0;
  assign o_trx_tx.valid = r.stage_ok &&
                          ((r.st == hrl_pkg::ST_LOAD) || (r.st == hrl_pkg::ST_STREAM));
  assign o_trx_tx.data = buf_rdata;
  assign o_trx_tx_on = r.tx_on || r.ack;
  assign o_trx_preamble = r.preamble;
  assign o_trx_rx_on = (r.st == hrl_pkg::ST_SCAN) || (r.st == hrl_pkg::ST_RECV);
  assign o_trx_rx_ready = (r.st == hrl_pkg::ST_RECV) && r.detected && !r.ob1.valid;
  // the ack goes out on the channel the packet came in on
  assign o_trx_channel = (o_trx_rx_on || r.ack) ? ch_num(r.scan_idx) : ch_num(r.hop_idx);
  assign o_trx_freq_khz = ch_khz(o_trx_channel);
  assign o_trx_ack_send = r.ack;
  // bit 4 keeps the device awake while idle in stand-by
  assign o_low_power_state = ((r.st == hrl_pkg::ST_IDLE) || (r.st == hrl_pkg::ST_SCAN)) &&
                             (r.wr_ptr == 7'h00) && !r.ob0.valid && !o_rts &&
                             !(r.dis_s2 && r.cfg[hrl_pkg::CFG_STANDBY_AWAKE_BIT]);

endmodule // hrl_link

//--- tb/hrl_link_properties.sv
// Purpose: port checks of the radio link control
// Assumes: one clock, asynchronous reset active low
// Notes: bound into every hrl_link
`timescale 1ns/10ps
module hrl_link_properties (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic o_rts,
  input wire logic o_trx_tx_on,
  input wire logic o_trx_preamble,
  input wire logic i_trx_tx_done,
  input wire logic o_trx_rx_on,
  input wire logic [7:0] o_trx_channel,
  input wire logic [19:0] o_trx_freq_khz,
  input wire logic o_trx_rx_ready,
  input wire logic i_trx_pkt_detect,
  input wire logic i_trx_pkt_end,
  input wire logic i_trx_ack_req,
  input wire logic o_trx_ack_send,
  input wire logic i_radio_receive_disable,
  input wire logic o_low_power_state
);
  default clocking dc @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  logic [15:0] pre_cnt;
  // cycles of the running wake preamble
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pre_cnt <= 16'h0000;
    end else begin
      pre_cnt <= o_trx_preamble ? pre_cnt + 16'h0001 : 16'h0000;
    end
  end
  sequence s_ack_due;
    o_trx_rx_on && i_trx_pkt_end && i_trx_ack_req;
  endsequence
  sequence s_ack_run;
    o_trx_ack_send && o_trx_tx_on;
  endsequence
  property p_ch_ok;
    o_trx_channel >= 8'hc9 && o_trx_channel <= 8'hfb;
  endproperty
  a_ch_ok: assert property (p_ch_ok) else $error("edge channel used");
  property p_freq;
    o_trx_freq_khz == 20'hdc370 + 20'(o_trx_channel - 8'hc8) * 20'h1f4;
  endproperty
  a_freq: assert property (p_freq) else $error("bad channel frequency");
  property p_pre_rts;
    o_trx_preamble |-> o_rts;
  endproperty
  a_pre_rts: assert property (p_pre_rts) else $error("host not held off");
  property p_tx_ch;
    o_trx_tx_on && $past(o_trx_tx_on) |-> $stable(o_trx_channel);
  endproperty
  a_tx_ch: assert property (p_tx_ch) else $error("channel moved in packet");
  property p_pre_len;
    $fell(o_trx_preamble) |-> pre_cnt >= 16'h0410;
  endproperty
  a_pre_len: assert property (p_pre_len) else $error("preamble too short");
  property p_rx_rdy;
    o_trx_rx_on && i_trx_pkt_detect |-> ##[1:2] o_trx_rx_ready;
  endproperty
  a_rx_rdy: assert property (p_rx_rdy) else $error("fifo not read");
  property p_ack;
    s_ack_due |-> ##[1:2] s_ack_run;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not sent");
  property p_ack_hold;
    o_trx_ack_send && !i_trx_tx_done |=> o_trx_ack_send;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
  property p_standby;
    i_radio_receive_disable [*6] |-> !o_trx_rx_on;
  endproperty
  a_standby: assert property (p_standby) else $error("receiver on in standby");
  property p_lp;
    o_low_power_state |-> !o_trx_tx_on && !o_rts;
  endproperty
  a_lp: assert property (p_lp) else $error("low power while busy");
endmodule // hrl_link_properties
bind hrl_link hrl_link_properties hrl_link_properties_i (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .o_rts(o_rts), .o_trx_tx_on(o_trx_tx_on),
  .o_trx_preamble(o_trx_preamble), .i_trx_tx_done(i_trx_tx_done),
  .o_trx_rx_on(o_trx_rx_on), .o_trx_channel(o_trx_channel),
  .o_trx_freq_khz(o_trx_freq_khz), .o_trx_rx_ready(o_trx_rx_ready),
  .i_trx_pkt_detect(i_trx_pkt_detect), .i_trx_pkt_end(i_trx_pkt_end),
  .i_trx_ack_req(i_trx_ack_req), .o_trx_ack_send(o_trx_ack_send),
  .i_radio_receive_disable(i_radio_receive_disable),
  .o_low_power_state(o_low_power_state)
);

//--- tb/hrl_host_model.sv
// Purpose: host controller on the flow-controlled serial side
// Assumes: one byte per call, random sink stalls
// Notes: stall input holds the sink off on demand
`timescale 1ns/10ps
module hrl_host_model (
  input wire logic i_sys_clk,
  input wire logic i_rts,
  input wire logic i_stall,
  input wire hrl_pkg::hrl_byte_t i_rx,
  output logic o_rx_ready,
  output hrl_pkg::hrl_byte_t o_tx
);
  initial begin
    o_tx = '0;
    o_rx_ready = 1'b0;
  end
  always @(posedge i_sys_clk) begin
    o_rx_ready <= !i_stall && (($urandom % 4) != 0);
  end
  task automatic send(input logic [7:0] b);
    @(posedge i_sys_clk);
    while (i_rts) begin
      @(posedge i_sys_clk);
    end
    o_tx <= '{valid: 1'b1, data: b};
    @(posedge i_sys_clk);
    o_tx <= '{valid: 1'b0, data: ~b};
  endtask
endmodule // hrl_host_model

//--- tb/tb_hrl_link.sv
// Purpose: self-checking bench of the radio link control
// Assumes: transceiver side driven here, host side by the model
// Notes: preamble set to its floor to keep the run short
`timescale 1ns/10ps
module tb_hrl_link;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic [31:0] rdata;
  hrl_pkg::hrl_byte_t host_rx, host_tx, trx_tx;
  hrl_pkg::hrl_byte_t trx_rx = '0;
  logic rts, host_rdy, tx_on, pre, rx_on, rx_rdy, ack, lp;
  logic [7:0] ch, ch1, ch2;
  logic [19:0] freq;
  logic [7:0] rssi = 8'h00;
  logic trx_rdy = 1'b0;
  logic tx_done = 1'b0;
  logic det = 1'b0;
  logic pend = 1'b0;
  logic ackreq = 1'b0;
  logic dis = 1'b0;
  logic stall = 1'b0;
  logic hi = 1'b0;
  int mismatches = 0;
  int compares = 0;
  logic [31:0] rd_q[$];
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  always #50 clk = ~clk;
  hrl_link hrl_link_i (.i_sys_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_host_rx(host_rx), .o_rts(rts),
    .o_host_tx(host_tx), .i_host_tx_ready(host_rdy), .o_trx_tx(trx_tx),
    .i_trx_tx_ready(trx_rdy), .o_trx_tx_on(tx_on), .o_trx_preamble(pre),
    .i_trx_tx_done(tx_done), .o_trx_rx_on(rx_on), .o_trx_channel(ch),
    .o_trx_freq_khz(freq), .i_trx_rssi(rssi), .i_trx_rx(trx_rx), .o_trx_rx_ready(rx_rdy),
    .i_trx_pkt_detect(det), .i_trx_pkt_end(pend), .i_trx_ack_req(ackreq),
    .o_trx_ack_send(ack), .i_radio_receive_disable(dis), .o_low_power_state(lp));
  hrl_host_model hrl_host_model_i (.i_sys_clk(clk), .i_rts(rts), .i_stall(stall),
    .i_rx(host_tx), .o_rx_ready(host_rdy), .o_tx(host_rx));
  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    cmp_reg({24'h0, g}, {24'h0, e});
  endtask
  task automatic cmp_flag(input logic g, input logic e);
    cmp_reg({31'h0, g}, {31'h0, e});
  endtask
  task automatic wait_lvl(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 3000) begin
      @(posedge clk);
      n++;
    end
    cmp_flag(s, v);
  endtask
  // ****************************************
  // bus, serial and transceiver drivers
  // ****************************************
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    rd_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic send_pkt(output logic [7:0] c);
    logic [7:0] b;
    int n;
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      tx_q.push_back(b);
      hrl_host_model_i.send(b);
    end
    n = 0;
    wait_lvl(pre, 1'b1);
    cmp_flag(rts, 1'b1);
    c = ch;
    while (tx_q.size() != 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    cmp_flag(tx_q.size() == 0, 1'b1);
    cmp_flag(tx_on, 1'b1);
    repeat (4) @(posedge clk);
    tx_done <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
    wait_lvl(rts, 1'b0);
  endtask
  task automatic rx_byte(input logic [7:0] b);
    int n;
    n = 0;
    rx_q.push_back(b);
    trx_rx <= '{valid: 1'b1, data: b};
    @(posedge clk);
    while (!rx_rdy && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask
  always @(posedge clk) begin
    trx_rdy <= ($urandom % 3) != 0;
    rssi <= hi ? 8'hff : 8'($urandom % 8);
    if (rd_d) cmp_reg(rdata, rd_q.pop_front());
    if (trx_tx.valid && trx_rdy) cmp_byte(trx_tx.data, tx_q.pop_front());
    if (host_tx.valid && host_rdy) cmp_byte(host_tx.data, rx_q.pop_front());
    rd_d <= rd;
  end
  // ****************************************
  // main sequence and verdict
  // ****************************************
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h963fdabf));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_reg(8'h00, 32'h0000400a);
    rd_reg(8'h04, 32'h00000014);
    rd_reg(8'h08, 32'h00000000);
    rd_reg(8'h10, 32'h00000000);
    wr_reg(8'h00, 32'h0000040a);
    wr_reg(8'h04, 32'h00000001);
    rd_reg(8'h00, 32'h0000040a);
    send_pkt(ch1);
    send_pkt(ch2);
    cmp_flag(ch1 != ch2, 1'b1);
    cmp_byte(ch1, 8'hdc);
    cmp_byte(ch2, 8'hef);
    repeat (16000) @(posedge clk);
    hi <= 1'b1;
    repeat (30) @(posedge clk);
    hi <= 1'b0;
    ch1 = ch;
    repeat (40) @(posedge clk);
    cmp_byte(ch, ch1);
    cmp_flag(rx_on, 1'b1);
    det <= 1'b1;
    @(posedge clk);
    det <= 1'b0;
    stall <= 1'b1;
    fork
      begin
        repeat (40) @(posedge clk);
        cmp_flag(rx_rdy, 1'b0);
        stall <= 1'b0;
      end
      for (int i = 0; i < 6; i++) begin
        rx_byte(8'($urandom));
      end
    join
    trx_rx <= '{valid: 1'b0, data: 8'ha5};
    pend <= 1'b1;
    ackreq <= 1'b1;
    @(posedge clk);
    pend <= 1'b0;
    ackreq <= 1'b0;
    wait_lvl(ack, 1'b1);
    cmp_byte(ch, ch1);
    tx_done <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
    wait_lvl(ack, 1'b0);
    repeat (30) @(posedge clk);
    cmp_flag(rx_q.size() == 0, 1'b1);
    dis <= 1'b1;
    repeat (10) @(posedge clk);
    cmp_flag(rx_on, 1'b0);
    cmp_flag(lp, 1'b1);
    rd_reg(8'h0c, 32'h0100ef00);
    wr_reg(8'h08, 32'h00000010);
    repeat (4) @(posedge clk);
    cmp_flag(lp, 1'b0);
    send_pkt(ch2);
    cmp_byte(ch2, 8'hcf);
    dis <= 1'b0;
    repeat (10) @(posedge clk);
    end_of_test();
  end
endmodule // tb_hrl_link
